// File: hw/tba_pkg.sv
package tba_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int NUM_ACC = 5;

    // Accumulator slots in the bank
    localparam int ACC_MAIN = 0;
    localparam int ACC_VOL = 1;
    localparam int ACC_SECOND = 2;
    localparam int ACC_THIRD = 3;
    localparam int ACC_FOURTH = 4;

    // Tariff type codes, the decimal selector value held in binary
    localparam logic [7:0] TT_NONE = 8'h00;
    localparam logic [7:0] TT_POWER = 8'h0B;
    localparam logic [7:0] TT_FLOW = 8'h0C;
    localparam logic [7:0] TT_DELTA_T = 8'h0D;
    localparam logic [7:0] TT_INLET = 8'h0E;
    localparam logic [7:0] TT_OUTLET = 8'h0F;
    localparam logic [7:0] TT_TIME = 8'h13;
    localparam logic [7:0] TT_HEAT_COOL = 8'h14;
    localparam logic [7:0] TT_PQ = 8'h15;

    // Band masks: bit 0 second, bit 1 third, bit 2 fourth accumulator
    localparam logic [2:0] MASK_NONE = 3'h0;
    localparam logic [2:0] MASK_SECOND = 3'h1;
    localparam logic [2:0] MASK_THIRD = 3'h2;
    localparam logic [2:0] MASK_FOURTH = 3'h4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_LIMIT2 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LIMIT3 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_LIMIT4 = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_HC_THRESH = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_MAIN = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_VOLUME = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ACC_SECOND = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_ACC_THIRD = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_ACC_FOURTH = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_INTEG_CNT = 8'h2C;

    localparam int CTRL_CLEAR_BIT = 8;
    localparam logic [7:0] TYPE_RST = TT_NONE;
    localparam logic [DATA_W-1:0] WORD_RST = 32'h0;

endpackage

// File: hw/tba_accum.sv
`timescale 1ns/1ps

module tba_accum import tba_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clear,
    input wire logic add_en,
    input wire logic [DATA_W-1:0] increment,
    // Result
    output logic [DATA_W-1:0] value
);

    typedef struct packed {
        logic [DATA_W-1:0] acc;
    } tba_acc_state_t;

    tba_acc_state_t r;
    tba_acc_state_t next_r;

    // An increment arriving with a clear is kept, so no consumption is lost
    always_comb begin
        next_r = r;
        next_r.acc = (clear ? WORD_RST : r.acc) + (add_en ? increment : WORD_RST);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign value = r.acc;

    a_acc_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !clear && !add_en |=> $stable(value))
        else $error("accumulator moved without add or clear");

endmodule

// File: hw/tba_band_select.sv
`timescale 1ns/1ps

module tba_band_select import tba_pkg::*; (
    // Configuration
    input wire logic [7:0] tariff_type_select,
    input wire logic [DATA_W-1:0] tariff_limit_second,
    input wire logic [DATA_W-1:0] tariff_limit_third,
    input wire logic [DATA_W-1:0] tariff_limit_fourth,
    input wire logic [DATA_W-1:0] heat_cool_switch_threshold,
    // Measurements
    input wire logic [DATA_W-1:0] power,
    input wire logic [DATA_W-1:0] flow,
    input wire logic [DATA_W-1:0] delta_t,
    input wire logic [DATA_W-1:0] inlet_temperature,
    input wire logic [DATA_W-1:0] outlet_temperature,
    input wire logic [DATA_W-1:0] time_of_day,
    // Result
    output logic [2:0] add_mask,
    output logic use_volume
);

    // Ascending bands: strict above the lower limit, inclusive at the upper
    function automatic logic [2:0] band_up(input logic [DATA_W-1:0] v, input logic [DATA_W-1:0] l2,
                                           input logic [DATA_W-1:0] l3, input logic [DATA_W-1:0] l4);
        logic l4_on;
        l4_on = (l4 != WORD_RST);
        if (v <= l2) begin
            return MASK_NONE;
        end else if (v <= l3) begin
            return MASK_SECOND;
        end else if (!l4_on || v <= l4) begin
            return MASK_THIRD;
        end else begin
            return MASK_FOURTH;
        end
    endfunction

    logic l4_on;
    assign l4_on = (tariff_limit_fourth != WORD_RST);

    always_comb begin
        add_mask = MASK_NONE;
        use_volume = 1'b0;
        case (tariff_type_select)
            TT_NONE: begin
                add_mask = MASK_NONE;
            end
            TT_POWER: begin
                add_mask = band_up(power, tariff_limit_second, tariff_limit_third, tariff_limit_fourth);
            end
            TT_FLOW: begin
                add_mask = band_up(flow, tariff_limit_second, tariff_limit_third, tariff_limit_fourth);
            end
            TT_DELTA_T: begin
                // Falling bands: a small temperature drop is the costly case
                if (delta_t >= tariff_limit_second) begin
                    add_mask = MASK_NONE;
                end else if (delta_t >= tariff_limit_third) begin
                    add_mask = MASK_SECOND;
                end else if (!l4_on || delta_t >= tariff_limit_fourth) begin
                    add_mask = MASK_THIRD;
                end else begin
                    add_mask = MASK_FOURTH;
                end
            end
            TT_INLET: begin
                add_mask = band_up(inlet_temperature, tariff_limit_second, tariff_limit_third,
                                   tariff_limit_fourth);
            end
            TT_OUTLET: begin
                add_mask = band_up(outlet_temperature, tariff_limit_second, tariff_limit_third,
                                   tariff_limit_fourth);
            end
            TT_TIME: begin
                // Outside the two day windows the night band applies, wrapping midnight
                if (time_of_day >= tariff_limit_second && time_of_day < tariff_limit_third) begin
                    add_mask = MASK_SECOND;
                end else if (time_of_day >= tariff_limit_third && (!l4_on || time_of_day < tariff_limit_fourth)) begin
                    add_mask = MASK_THIRD;
                end else begin
                    add_mask = l4_on ? MASK_FOURTH : MASK_THIRD;
                end
            end
            TT_HEAT_COOL: begin
                use_volume = 1'b1;
                if (inlet_temperature > outlet_temperature && inlet_temperature >= heat_cool_switch_threshold) begin
                    add_mask = MASK_SECOND;
                end else if (outlet_temperature > inlet_temperature &&
                             inlet_temperature <= heat_cool_switch_threshold) begin
                    add_mask = MASK_THIRD;
                end else begin
                    add_mask = MASK_NONE;
                end
            end
            TT_PQ: begin
                add_mask = {1'b0, flow > tariff_limit_third, power > tariff_limit_second};
            end
            default: begin
                add_mask = MASK_NONE;
            end
        endcase
    end

endmodule

// File: hw/tba_tariff_band_accumulator.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Selector 00 adds nothing to tariff accumulators; main register still accumulates.
// - Power tariff: power above second, at most third limit adds to second accumulator.
// - Power tariff: power above third, at most fourth limit adds to third accumulator.
// - Power tariff: above fourth limit adds to fourth; at or below second, main only.
// - Flow tariff: flow above second, at most third limit adds to second accumulator.
// - Flow tariff: flow above third, at most fourth limit adds to third accumulator.
// - Flow tariff: above fourth limit adds to fourth; at or below second, main only.
// - Time tariff: limits are day times starting second, third, fourth accumulators.
// - Heat/cool tariff: heat volume to second, cooling volume to third, fourth unused.
// - PQ tariff: power over second limit and flow over third limit add independently.
// - Inlet and outlet temperature tariffs band energy against the three limits.
// - Main register accumulates every integration; tariff accumulators only when banded.
// - Limit conditions are evaluated at every integration step.
// - Fourth limit zero disables the fourth accumulator; second and third remain.
module tba_tariff_band_accumulator import tba_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement front end
    input wire logic integ_strobe,
    input wire logic [DATA_W-1:0] energy_inc,
    input wire logic [DATA_W-1:0] volume_inc,
    input wire logic [DATA_W-1:0] power,
    input wire logic [DATA_W-1:0] flow,
    input wire logic [DATA_W-1:0] delta_t,
    input wire logic [DATA_W-1:0] inlet_temperature,
    input wire logic [DATA_W-1:0] outlet_temperature,
    input wire logic [DATA_W-1:0] time_of_day,
    // Accumulated values and last band mask for display
    output logic [DATA_W-1:0] main_energy_accum,
    output logic [DATA_W-1:0] total_volume_accum,
    output logic [DATA_W-1:0] tariff_accum_second,
    output logic [DATA_W-1:0] tariff_accum_third,
    output logic [DATA_W-1:0] tariff_accum_fourth,
    output logic [2:0] band_mask
);

    typedef struct packed {
        logic [7:0] tariff_type_select;
        logic [DATA_W-1:0] tariff_limit_second;
        logic [DATA_W-1:0] tariff_limit_third;
        logic [DATA_W-1:0] tariff_limit_fourth;
        logic [DATA_W-1:0] heat_cool_switch_threshold;
        logic clear;
        logic [2:0] last_mask;
        logic [DATA_W-1:0] integ_count;
        logic [DATA_W-1:0] rdata;
    } tba_regs_t;

    tba_regs_t r;
    tba_regs_t next_r;

    logic [2:0] add_mask;
    logic use_volume;
    logic [DATA_W-1:0] tariff_inc;
    logic [DATA_W-1:0] acc_value [NUM_ACC];
    logic [NUM_ACC-1:0] acc_add;
    logic [DATA_W-1:0] acc_inc [NUM_ACC];
    logic wr_access;
    logic rd_setup;

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL, OFS_LIMIT2, OFS_LIMIT3, OFS_LIMIT4, OFS_HC_THRESH, OFS_STATUS,
            OFS_MAIN, OFS_VOLUME, OFS_ACC_SECOND, OFS_ACC_THIRD, OFS_ACC_FOURTH, OFS_INTEG_CNT: begin
                return 1'b1;
            end
            default: begin
                return 1'b0;
            end
        endcase
    endfunction

    tba_band_select u_band (
        .tariff_type_select(r.tariff_type_select),
        .tariff_limit_second(r.tariff_limit_second),
        .tariff_limit_third(r.tariff_limit_third),
        .tariff_limit_fourth(r.tariff_limit_fourth),
        .heat_cool_switch_threshold(r.heat_cool_switch_threshold),
        .power(power),
        .flow(flow),
        .delta_t(delta_t),
        .inlet_temperature(inlet_temperature),
        .outlet_temperature(outlet_temperature),
        .time_of_day(time_of_day),
        .add_mask(add_mask),
        .use_volume(use_volume)
    );

    // Tariff accumulators carry volume only in the heat/cooling split
    assign tariff_inc = use_volume ? volume_inc : energy_inc;

    always_comb begin
        acc_add[ACC_MAIN] = integ_strobe;
        acc_inc[ACC_MAIN] = energy_inc;
        acc_add[ACC_VOL] = integ_strobe;
        acc_inc[ACC_VOL] = volume_inc;
        acc_add[ACC_SECOND] = integ_strobe && add_mask[0];
        acc_add[ACC_THIRD] = integ_strobe && add_mask[1];
        acc_add[ACC_FOURTH] = integ_strobe && add_mask[2];
        acc_inc[ACC_SECOND] = tariff_inc;
        acc_inc[ACC_THIRD] = tariff_inc;
        acc_inc[ACC_FOURTH] = tariff_inc;
    end

    for (genvar i = 0; i < NUM_ACC; i++) begin : g_acc
        tba_accum u_acc (
            .pclk(pclk),
            .presetn(presetn),
            .clear(r.clear),
            .add_en(acc_add[i]),
            .increment(acc_inc[i]),
            .value(acc_value[i])
        );
    end

    assign wr_access = psel && penable && pwrite && addr_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    always_comb begin
        next_r = r;
        next_r.clear = 1'b0;
        if (integ_strobe) begin
            next_r.last_mask = add_mask;
            next_r.integ_count = r.integ_count + 32'h1;
        end
        if (wr_access) begin
            case (paddr)
                OFS_CTRL: begin
                    next_r.tariff_type_select = pwdata[7:0];
                    next_r.clear = pwdata[CTRL_CLEAR_BIT];
                end
                OFS_LIMIT2: begin
                    next_r.tariff_limit_second = pwdata;
                end
                OFS_LIMIT3: begin
                    next_r.tariff_limit_third = pwdata;
                end
                OFS_LIMIT4: begin
                    next_r.tariff_limit_fourth = pwdata;
                end
                OFS_HC_THRESH: begin
                    next_r.heat_cool_switch_threshold = pwdata;
                end
                default: begin
                    next_r.clear = 1'b0;
                end
            endcase
        end
        // Read data is captured in the setup cycle so prdata comes from a flop with zero wait states
        if (rd_setup) begin
            case (paddr)
                OFS_CTRL: next_r.rdata = DATA_W'(r.tariff_type_select);
                OFS_LIMIT2: next_r.rdata = r.tariff_limit_second;
                OFS_LIMIT3: next_r.rdata = r.tariff_limit_third;
                OFS_LIMIT4: next_r.rdata = r.tariff_limit_fourth;
                OFS_HC_THRESH: next_r.rdata = r.heat_cool_switch_threshold;
                OFS_STATUS: next_r.rdata = DATA_W'(r.last_mask);
                OFS_MAIN: next_r.rdata = acc_value[ACC_MAIN];
                OFS_VOLUME: next_r.rdata = acc_value[ACC_VOL];
                OFS_ACC_SECOND: next_r.rdata = acc_value[ACC_SECOND];
                OFS_ACC_THIRD: next_r.rdata = acc_value[ACC_THIRD];
                OFS_ACC_FOURTH: next_r.rdata = acc_value[ACC_FOURTH];
                OFS_INTEG_CNT: next_r.rdata = r.integ_count;
                default: next_r.rdata = WORD_RST;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign main_energy_accum = acc_value[ACC_MAIN];
    assign total_volume_accum = acc_value[ACC_VOL];
    assign tariff_accum_second = acc_value[ACC_SECOND];
    assign tariff_accum_third = acc_value[ACC_THIRD];
    assign tariff_accum_fourth = acc_value[ACC_FOURTH];
    assign band_mask = r.last_mask;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0] tt;
    logic [DATA_W-1:0] l2;
    logic [DATA_W-1:0] l3;
    logic [DATA_W-1:0] l4;
    assign tt = r.tariff_type_select;
    assign l2 = r.tariff_limit_second;
    assign l3 = r.tariff_limit_third;
    assign l4 = r.tariff_limit_fourth;

    a_no_tariff_idle: assert property (integ_strobe && tt == TT_NONE && !r.clear |=>
        $stable(tariff_accum_second) && $stable(tariff_accum_third) && $stable(tariff_accum_fourth))
        else $error("tariff accumulator moved with no tariff selected");
    a_power_band_two: assert property (integ_strobe && !r.clear && tt == TT_POWER && power > l2 && power <= l3 |=>
        tariff_accum_second == $past(tariff_accum_second) + $past(energy_inc) && $stable(tariff_accum_third))
        else $error("power band two not accumulated");
    a_power_band_three: assert property (integ_strobe && !r.clear && tt == TT_POWER && power > l3 &&
        (power <= l4 || l4 == WORD_RST) |=> tariff_accum_third == $past(tariff_accum_third) + $past(energy_inc))
        else $error("power band three not accumulated");
    a_power_top_low: assert property (integ_strobe && !r.clear && tt == TT_POWER && l4 != WORD_RST &&
        (power > l4 || power <= l2) |=> $stable(tariff_accum_second) && $stable(tariff_accum_third))
        else $error("power above top or below bottom touched middle bands");
    a_flow_band_two: assert property (integ_strobe && !r.clear && tt == TT_FLOW && flow > l2 && flow <= l3 |=>
        tariff_accum_second == $past(tariff_accum_second) + $past(energy_inc))
        else $error("flow band two not accumulated");
    a_flow_band_three: assert property (integ_strobe && !r.clear && tt == TT_FLOW && flow > l3 && flow <= l4 |=>
        tariff_accum_third == $past(tariff_accum_third) + $past(energy_inc) && $stable(tariff_accum_fourth))
        else $error("flow band three not accumulated");
    a_flow_band_four: assert property (integ_strobe && !r.clear && tt == TT_FLOW && l4 != WORD_RST && flow > l4 |=>
        tariff_accum_fourth == $past(tariff_accum_fourth) + $past(energy_inc) && band_mask == MASK_FOURTH)
        else $error("flow band four not accumulated");
    a_time_day_band: assert property (integ_strobe && !r.clear && tt == TT_TIME && time_of_day >= l2 &&
        time_of_day < l3 |=> tariff_accum_second == $past(tariff_accum_second) + $past(energy_inc))
        else $error("day window not accumulated");
    a_heat_volume: assert property (integ_strobe && !r.clear && tt == TT_HEAT_COOL |=>
        $stable(tariff_accum_fourth) && total_volume_accum == $past(total_volume_accum) + $past(volume_inc))
        else $error("heat/cool tariff misused fourth or volume");
    a_pq_both: assert property (integ_strobe && !r.clear && tt == TT_PQ && power > l2 && flow > l3 |=>
        band_mask == (MASK_SECOND | MASK_THIRD) && $stable(tariff_accum_fourth))
        else $error("pq tariff did not add both");
    a_inlet_band: assert property (integ_strobe && !r.clear && tt == TT_INLET && inlet_temperature <= l2 |=>
        band_mask == MASK_NONE)
        else $error("inlet below second limit selected a band");
    a_main_always: assert property (integ_strobe && !r.clear |=>
        main_energy_accum == $past(main_energy_accum) + $past(energy_inc))
        else $error("main register missed an integration");
    a_every_step: assert property (integ_strobe |=> r.integ_count == $past(r.integ_count) + 32'h1)
        else $error("integration step not counted");
    a_fourth_off: assert property (integ_strobe && l4 == WORD_RST |=> !band_mask[2])
        else $error("fourth accumulator used while disabled");
    a_single_band: assert property (integ_strobe && tt != TT_PQ |=> $onehot0(band_mask))
        else $error("more than one band selected");

    c_power_top: cover property (integ_strobe && tt == TT_POWER && add_mask == MASK_FOURTH);
    c_cooling: cover property (integ_strobe && tt == TT_HEAT_COOL && add_mask == MASK_THIRD);
    c_pq_both: cover property (integ_strobe && tt == TT_PQ && add_mask == (MASK_SECOND | MASK_THIRD));
    c_bus_error: cover property (pslverr);

endmodule

// File: bench/tba_tariff_band_accumulator_bench.sv
`timescale 1ns/1ps

module tba_tariff_band_accumulator_bench import tba_pkg::*; ();
    typedef struct packed {
        logic [7:0] tt;
        logic [31:0] pw, fl, ti, to, td;
        logic [2:0] mask;
    } tba_row_t;
    localparam int NROWS = 22;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata;
    logic pready, pslverr, integ_strobe = 1'b0;
    logic [DATA_W-1:0] energy_inc = '0, volume_inc = '0, power = '0, flow = '0, delta_t = '0;
    logic [DATA_W-1:0] inlet_temperature = '0, outlet_temperature = '0, time_of_day = '0;
    logic [DATA_W-1:0] main_energy_accum, total_volume_accum;
    logic [DATA_W-1:0] tariff_accum_second, tariff_accum_third, tariff_accum_fourth;
    logic [2:0] band_mask;
    int fails = 0, check_count = 0, cycles = 0;
    tba_row_t rows [NROWS];
    logic [31:0] rd, inc, cnt0;
    logic err;

    always #20 pclk = ~pclk;

    tba_tariff_band_accumulator dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .integ_strobe(integ_strobe), .energy_inc(energy_inc), .volume_inc(volume_inc),
        .power(power), .flow(flow), .delta_t(delta_t), .inlet_temperature(inlet_temperature),
        .outlet_temperature(outlet_temperature), .time_of_day(time_of_day),
        .main_energy_accum(main_energy_accum), .total_volume_accum(total_volume_accum),
        .tariff_accum_second(tariff_accum_second), .tariff_accum_third(tariff_accum_third),
        .tariff_accum_fourth(tariff_accum_fourth), .band_mask(band_mask));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Generous ceiling: the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdo, output logic e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdo = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next call from re-driving psel in this time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask

    task automatic strobe(input logic [31:0] e);
        energy_inc <= e;
        volume_inc <= 32'h7;
        integ_strobe <= 1'b1;
        @(posedge pclk);
        integ_strobe <= 1'b0;
    endtask

    initial begin
        rows[0] = '{TT_NONE, 32'hFA, 32'hFA, 32'h0, 32'h0, 32'h0, 3'h0};
        rows[1] = '{TT_POWER, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 3'h0};
        rows[2] = '{TT_POWER, 32'h65, 32'h0, 32'h0, 32'h0, 32'h0, 3'h1};
        rows[3] = '{TT_POWER, 32'hC8, 32'h0, 32'h0, 32'h0, 32'h0, 3'h1};
        rows[4] = '{TT_POWER, 32'hC9, 32'h0, 32'h0, 32'h0, 32'h0, 3'h2};
        rows[5] = '{TT_POWER, 32'h12C, 32'h0, 32'h0, 32'h0, 32'h0, 3'h2};
        rows[6] = '{TT_POWER, 32'h12D, 32'h0, 32'h0, 32'h0, 32'h0, 3'h4};
        rows[7] = '{TT_FLOW, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 3'h0};
        rows[8] = '{TT_FLOW, 32'h0, 32'h96, 32'h0, 32'h0, 32'h0, 3'h1};
        rows[9] = '{TT_FLOW, 32'h0, 32'hFA, 32'h0, 32'h0, 32'h0, 3'h2};
        rows[10] = '{TT_FLOW, 32'h0, 32'h12D, 32'h0, 32'h0, 32'h0, 3'h4};
        rows[11] = '{TT_INLET, 32'h0, 32'h0, 32'hFA, 32'h0, 32'h0, 3'h2};
        rows[12] = '{TT_OUTLET, 32'h0, 32'h0, 32'h0, 32'h15E, 32'h0, 3'h4};
        rows[13] = '{TT_TIME, 32'h0, 32'h0, 32'h0, 32'h0, 32'h96, 3'h1};
        rows[14] = '{TT_TIME, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFA, 3'h2};
        rows[15] = '{TT_TIME, 32'h0, 32'h0, 32'h0, 32'h0, 32'h32, 3'h4};
        rows[16] = '{TT_PQ, 32'h96, 32'hFA, 32'h0, 32'h0, 32'h0, 3'h3};
        rows[17] = '{TT_PQ, 32'h32, 32'hFA, 32'h0, 32'h0, 32'h0, 3'h2};
        rows[18] = '{TT_HEAT_COOL, 32'h0, 32'h0, 32'h3C, 32'h28, 32'h0, 3'h1};
        rows[19] = '{TT_HEAT_COOL, 32'h0, 32'h0, 32'h1E, 32'h28, 32'h0, 3'h2};
        rows[20] = '{TT_DELTA_T, 32'h0, 32'h0, 32'h0, 32'h0, 32'h63, 3'h4};
        rows[21] = '{TT_INLET, 32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 3'h0};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(main_energy_accum | total_volume_accum | tariff_accum_second | tariff_accum_third | tariff_accum_fourth,
              32'h0);
        apb(1'b0, OFS_LIMIT2, 32'h0, rd, err);
        check(rd, 32'h0);
        wr(OFS_LIMIT2, 32'h64);
        wr(OFS_LIMIT3, 32'hC8);
        wr(OFS_LIMIT4, 32'h12C);
        wr(OFS_HC_THRESH, 32'h32);
        apb(1'b0, OFS_LIMIT3, 32'h0, rd, err);
        check(rd, 32'hC8);
        for (int i = 0; i < NROWS; i++) begin
            wr(OFS_CTRL, {23'h0, 1'b1, rows[i].tt});
            @(posedge pclk);
            power <= rows[i].pw;
            flow <= rows[i].fl;
            inlet_temperature <= rows[i].ti;
            outlet_temperature <= rows[i].to;
            time_of_day <= rows[i].td;
            delta_t <= rows[i].td;
            strobe(32'h10 + i);
            @(posedge pclk);
            inc = (rows[i].tt == TT_HEAT_COOL) ? 32'h7 : 32'h10 + i;
            check(main_energy_accum, 32'h10 + i);
            check(total_volume_accum, 32'h7);
            check(tariff_accum_second, rows[i].mask[0] ? inc : 32'h0);
            check(tariff_accum_third, rows[i].mask[1] ? inc : 32'h0);
            check(tariff_accum_fourth, rows[i].mask[2] ? inc : 32'h0);
            check({29'h0, band_mask}, {29'h0, rows[i].mask});
            apb(1'b0, OFS_STATUS, 32'h0, rd, err);
            check(rd, {29'h0, rows[i].mask});
        end
        // Back-to-back strobes landing in different bands
        wr(OFS_CTRL, {23'h0, 1'b1, TT_POWER});
        apb(1'b0, OFS_INTEG_CNT, 32'h0, cnt0, err);
        power <= 32'h12D;
        energy_inc <= 32'h3;
        integ_strobe <= 1'b1;
        @(posedge pclk);
        power <= 32'h65;
        energy_inc <= 32'h4;
        @(posedge pclk);
        integ_strobe <= 1'b0;
        @(posedge pclk);
        check(main_energy_accum, 32'h7);
        check(tariff_accum_fourth, 32'h3);
        check(tariff_accum_second, 32'h4);
        apb(1'b0, OFS_INTEG_CNT, 32'h0, rd, err);
        check(rd, cnt0 + 32'h2);
        check({31'h0, err}, 32'h0);
        // Main register is read-only from the bus
        wr(OFS_MAIN, 32'hFFFF);
        apb(1'b0, OFS_MAIN, 32'h0, rd, err);
        check(rd, 32'h7);
        // Unmapped address answers with an error and zero data
        apb(1'b0, 8'h30, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        // Fourth limit zero: top band folds into the third accumulator
        wr(OFS_LIMIT4, 32'h0);
        wr(OFS_CTRL, {23'h0, 1'b1, TT_POWER});
        @(posedge pclk);
        power <= 32'h3E8;
        strobe(32'h9);
        @(posedge pclk);
        check(tariff_accum_third, 32'h9);
        check(tariff_accum_fourth, 32'h0);
        check(main_energy_accum, 32'h9);
        // Reset in mid-run returns accumulators, mask and limits to zero
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(main_energy_accum | tariff_accum_third | {29'h0, band_mask}, 32'h0);
        apb(1'b0, OFS_LIMIT3, 32'h0, rd, err);
        check(rd, 32'h0);
        report_and_stop();
    end
endmodule
